// *** psctl_host.sv ***
// host controller driving an asynchronous pseudo-static ram over its pins
// assumes a user port synchronous to ref_clk; pins are registered outputs
`timescale 1ns/1ps
module psctl_host
   import psctl_pkg::*;
#(
   parameter int POWER_ON_WAIT = POWER_ON_CYCLES,
   parameter int DEEP_PULSE    = DEEP_PULSE_CYCLES,
   parameter int DEEP_EXIT     = DEEP_EXIT_CYCLES,
   parameter int REFRESH_SPAN  = REFRESH_CYCLES
) (
   input  wire logic              ref_clk,
   input  wire logic              reset_n,
   input  wire logic              req_valid,
   input  wire psctl_op_e         req_op,
   input  wire logic [ADDR_W-1:0] req_addr,
   input  wire logic [DATA_W-1:0] req_wdata,
   input  wire logic [1:0]        req_lanes,
   input  wire logic [PAGE_BITS-1:0] req_count,
   input  wire logic              req_end_by_select,
   output logic                   req_ready,
   output logic                   rsp_valid,
   output logic [DATA_W-1:0]      rsp_rdata,
   output logic                   data_lost,
   output logic [ADDR_W-1:0]      mem_addr,
   output logic                   select_n,
   output logic                   power_select,
   output logic                   output_en_n,
   output logic                   write_n,
   output logic                   low_lane_n,
   output logic                   high_lane_n,
   output logic [DATA_W-1:0]      mem_dq_out,
   output logic                   mem_dq_oe,
   input  wire logic [DATA_W-1:0] mem_dq_in
);
   typedef enum logic [3:0] {
      S_POWER_ON, S_IDLE, S_RD, S_PAGE, S_WR_SETUP, S_WR_PULSE, S_WR_END,
      S_RECOVER, S_DEEP, S_DEEP_EXIT
   } psctl_state_e;

   psctl_state_e         state;
   logic                 tmr_load;
   logic [CNT_W-1:0]     tmr_value;
   logic                 tmr_done;
   logic                 ref_load;
   logic                 ref_done;
   logic [PAGE_BITS-1:0] words_left;
   logic                 by_select;

   function automatic logic [CNT_W-1:0] cyc(input int n);
      cyc = CNT_W'(n - 1);
   endfunction

   psctl_timer #(.W(CNT_W)) u_tmr (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .load    (tmr_load),
      .value   (tmr_value),
      .done    (tmr_done)
   );

   // refresh window watchdog; restarts on each full-length cycle
   psctl_timer #(.W(CNT_W)) u_ref (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .load    (ref_load),
      .value   (cyc(REFRESH_SPAN)),
      .done    (ref_done)
   );

   always_comb begin
      tmr_load  = 1'b0;
      tmr_value = '0;
      case (state)
         S_IDLE: begin
            if (req_valid && req_ready) begin
               tmr_load = 1'b1;
               case (req_op)
                  PSCTL_OP_READ,
                  PSCTL_OP_PAGE:  tmr_value = cyc(READ_CYCLES);
                  PSCTL_OP_WRITE: tmr_value = cyc(WRITE_CYCLES - WRITE_PULSE_NS / CLK_PERIOD_NS);
                  PSCTL_OP_SLEEP: tmr_value = cyc(DEEP_PULSE);
                  default:        tmr_value = '0;
               endcase
            end
         end
         S_RD, S_PAGE: begin
            if (tmr_done && words_left != '0) begin
               tmr_load  = 1'b1;
               tmr_value = cyc(PAGE_CYCLES);
            end else if (tmr_done) begin
               tmr_load  = 1'b1;
               tmr_value = cyc(RECOVER_CYCLES);
            end
         end
         S_WR_SETUP: begin
            if (tmr_done) begin
               tmr_load  = 1'b1;
               tmr_value = cyc((WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
            end
         end
         S_WR_PULSE, S_WR_END: begin
            if (tmr_done) begin
               tmr_load  = 1'b1;
               tmr_value = cyc((SELECT_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
            end
         end
         S_DEEP: begin
            if (tmr_done) begin
               tmr_load  = 1'b1;
               tmr_value = cyc(DEEP_EXIT);
            end
         end
         default: begin
            tmr_load  = 1'b0;
            tmr_value = '0;
         end
      endcase
   end

   // idle expiry only holds ready low for one cycle, then rearms
   assign ref_load = (state == S_POWER_ON) || (state == S_DEEP) ||
                     (state == S_IDLE && ref_done) ||
                     ((state == S_RD || state == S_PAGE || state == S_WR_END) &&
                      tmr_done);

   // power-on wait counts its own pon_count down from reset; the main timer is not loaded
   logic started;
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         started <= 1'b0;
      end else begin
         started <= 1'b1;
      end
   end

   logic [CNT_W-1:0] pon_count;
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pon_count <= CNT_W'(POWER_ON_WAIT - 1);
      end else if (state == S_POWER_ON && pon_count != '0) begin
         pon_count <= pon_count - 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         state      <= S_POWER_ON;
         words_left <= '0;
         by_select  <= 1'b0;
      end else begin
         case (state)
            S_POWER_ON: if (started && pon_count == '0) state <= S_IDLE;
            S_IDLE: begin
               if (req_valid && req_ready) begin
                  by_select  <= req_end_by_select;
                  words_left <= (req_op == PSCTL_OP_PAGE) ? req_count : '0;
                  case (req_op)
                     PSCTL_OP_READ:  state <= S_RD;
                     PSCTL_OP_PAGE:  state <= S_PAGE;
                     PSCTL_OP_WRITE: state <= S_WR_SETUP;
                     PSCTL_OP_SLEEP: state <= S_DEEP;
                     default:        state <= S_IDLE;
                  endcase
               end
            end
            S_RD, S_PAGE: begin
               if (tmr_done && words_left != '0) begin
                  words_left <= words_left - 1'b1;
                  state      <= S_PAGE;
               end else if (tmr_done) begin
                  state <= S_RECOVER;
               end
            end
            S_WR_SETUP: if (tmr_done) state <= S_WR_PULSE;
            S_WR_PULSE: if (tmr_done) state <= S_WR_END;
            S_WR_END:   if (tmr_done) state <= S_IDLE;
            S_RECOVER:  if (tmr_done) state <= S_IDLE;
            S_DEEP:     if (tmr_done) state <= S_DEEP_EXIT;
            S_DEEP_EXIT: if (tmr_done) state <= S_IDLE;
            default:    state <= S_IDLE;
         endcase
      end
   end

   // pin drive, registered from next state decisions
   logic in_write;
   logic in_read;
   assign in_write = (state == S_WR_SETUP) || (state == S_WR_PULSE) ||
                     (state == S_WR_END && !tmr_done);
   assign in_read  = (state == S_RD) || (state == S_PAGE);

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         select_n     <= 1'b1;
         power_select <= 1'b1;
         output_en_n  <= 1'b1;
         write_n      <= 1'b1;
         low_lane_n   <= 1'b1;
         high_lane_n  <= 1'b1;
         mem_addr     <= '0;
         mem_dq_out   <= '0;
         mem_dq_oe    <= 1'b0;
      end else begin
         power_select <= !(state == S_DEEP);
         if (state == S_IDLE && req_valid && req_ready && req_op != PSCTL_OP_SLEEP) begin
            mem_addr    <= req_addr;
            select_n    <= 1'b0;
            low_lane_n  <= !req_lanes[0];
            high_lane_n <= !req_lanes[1];
            output_en_n <= (req_op == PSCTL_OP_WRITE);
            mem_dq_out  <= req_wdata;
            mem_dq_oe   <= (req_op == PSCTL_OP_WRITE);
         end else if (in_read && tmr_done && words_left != '0) begin
            mem_addr[PAGE_BITS-1:0] <= mem_addr[PAGE_BITS-1:0] + 1'b1;
         end else if (in_read && tmr_done) begin
            select_n    <= 1'b1;
            output_en_n <= 1'b1;
            low_lane_n  <= 1'b1;
            high_lane_n <= 1'b1;
         end else if (state == S_WR_SETUP && tmr_done) begin
            write_n <= 1'b0;
         end else if (state == S_WR_PULSE && tmr_done) begin
            // end by strobe or by select; lanes drop no earlier than strobe
            if (by_select) begin
               select_n <= 1'b1;
            end else begin
               write_n <= 1'b1;
            end
         end else if (state == S_WR_END && tmr_done) begin
            write_n     <= 1'b1;
            select_n    <= 1'b1;
            low_lane_n  <= 1'b1;
            high_lane_n <= 1'b1;
            mem_dq_oe   <= 1'b0;
         end else if (!in_write && !in_read) begin
            mem_dq_oe <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
      end else begin
         rsp_valid <= in_read && tmr_done;
         if (in_read && tmr_done) begin
            rsp_rdata <= mem_dq_in;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         req_ready <= 1'b0;
      end else begin
         req_ready <= (state == S_IDLE) && !(req_valid && req_ready) && !ref_done;
      end
   end

   // set wins: entering deep power-down loses data; a write clears the flag
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         data_lost <= 1'b0;
      end else if (state == S_DEEP) begin
         data_lost <= 1'b1;
      end else if (state == S_WR_END && tmr_done) begin
         data_lost <= 1'b0;
      end
   end
endmodule

// *** psctl_host_monitor.sv ***
// pin and user-port assertions for the host controller
// assumes binding into psctl_host; one clock domain
`timescale 1ns/1ps
module psctl_host_monitor
   import psctl_pkg::*;
#(
   parameter int POWER_ON_WAIT = POWER_ON_CYCLES
) (
   input wire logic              ref_clk,
   input wire logic              reset_n,
   input wire logic              req_valid,
   input wire logic              req_ready,
   input wire psctl_op_e         req_op,
   input wire logic [PAGE_BITS-1:0] req_count,
   input wire logic              rsp_valid,
   input wire logic              data_lost,
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic              select_n,
   input wire logic              power_select,
   input wire logic              output_en_n,
   input wire logic              write_n,
   input wire logic              low_lane_n,
   input wire logic              high_lane_n,
   input wire logic              mem_dq_oe
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   int   since;
   logic take;
   assign take = req_valid && req_ready;
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) since <= 0;
      else if (since < POWER_ON_WAIT) since <= since + 1;
   end
   property p_power_on; since < POWER_ON_WAIT |-> select_n && power_select && !req_ready;
   endproperty
   a_power_on: assert property (p_power_on) else $error("early access");
   property p_no_clash; mem_dq_oe |-> output_en_n; endproperty
   a_no_clash: assert property (p_no_clash) else $error("drive clash");
   property p_strobe_in; $fell(write_n) |-> !select_n && !(low_lane_n && high_lane_n) && mem_dq_oe;
   endproperty
   a_strobe_in: assert property (p_strobe_in) else $error("late enable");
   property p_lanes_hold; !write_n && !select_n |-> $stable({low_lane_n, high_lane_n});
   endproperty
   a_lanes_hold: assert property (p_lanes_hold) else $error("lane moved");
   property p_pulse; $fell(write_n) |-> !write_n [*5]; endproperty
   a_pulse: assert property (p_pulse) else $error("short strobe");
   property p_full_cycle; $fell(select_n) |-> !select_n [*7]; endproperty
   a_full_cycle: assert property (p_full_cycle) else $error("short cycle");
   property p_page_bits; !select_n && !$past(select_n) |->
      mem_addr[ADDR_W-1:PAGE_BITS] == $past(mem_addr[ADDR_W-1:PAGE_BITS]); endproperty
   a_page_bits: assert property (p_page_bits) else $error("page left");
   property p_page_words; take && req_op == PSCTL_OP_PAGE && req_count != 0 |->
      ##8 rsp_valid ##3 rsp_valid; endproperty
   a_page_words: assert property (p_page_words) else $error("page timing");
   property p_deep_sel; !power_select |-> select_n; endproperty
   a_deep_sel: assert property (p_deep_sel) else $error("selected in sleep");
   property p_lost; $fell(power_select) |-> ##[0:2] data_lost; endproperty
   a_lost: assert property (p_lost) else $error("loss not flagged");
   c_page: cover property (take && req_op == PSCTL_OP_PAGE);
   c_sel_end: cover property ($rose(select_n) && !write_n);
   c_sleep: cover property ($fell(power_select));
endmodule
bind psctl_host psctl_host_monitor #(.POWER_ON_WAIT(POWER_ON_WAIT)) u_mon (
   .ref_clk, .reset_n, .req_valid, .req_ready, .req_op, .req_count, .rsp_valid,
   .data_lost, .mem_addr, .select_n, .power_select, .output_en_n, .write_n,
   .low_lane_n, .high_lane_n, .mem_dq_oe);

// *** psctl_mem_model.sv ***
// behavioural pseudo-static ram on the host controller pins
// assumes registered host pins; only 256 words, low address bits used
`timescale 1ns/1ps
module psctl_mem_model
   import psctl_pkg::*;
(
   input  wire logic [ADDR_W-1:0] mem_addr,
   input  wire logic              select_n,
   input  wire logic              power_select,
   input  wire logic              output_en_n,
   input  wire logic              write_n,
   input  wire logic              low_lane_n,
   input  wire logic              high_lane_n,
   input  wire logic [DATA_W-1:0] mem_dq_out,
   input  wire logic              mem_dq_oe,
   output logic      [DATA_W-1:0] mem_dq_in
);
   logic [DATA_W-1:0] cells [0:255];
   logic [DATA_W-1:0] word;
   logic              wr_on;
   logic              rd_on;
   assign word  = cells[mem_addr[7:0]];
   // either strobe or select may close the write window
   assign wr_on = !select_n && !write_n && power_select;
   // never drives inside a write window
   assign rd_on = !select_n && power_select && !output_en_n && write_n;
   always @(negedge wr_on) begin
      if (!low_lane_n) cells[mem_addr[7:0]][7:0] = mem_dq_out[7:0];
      if (!high_lane_n) cells[mem_addr[7:0]][15:8] = mem_dq_out[15:8];
   end
   always @(negedge power_select) begin
      if (select_n) begin
         for (int i = 0; i < 256; i++) cells[i] = 16'h5a5a ^ i[15:0];
      end
   end
   // undriven lanes show the inverse, page words follow the address
   always_comb begin
      mem_dq_in = mem_dq_oe ? mem_dq_out : ~word;
      if (rd_on && !low_lane_n) mem_dq_in[7:0] = word[7:0];
      if (rd_on && !high_lane_n) mem_dq_in[15:8] = word[15:8];
   end
endmodule

// *** psctl_pkg.sv ***
// package for the pseudo-static ram host controller
// assumes a 100 MHz ref_clk; write setup, pulse and select-high counts are derived in the host
package psctl_pkg;
   localparam int CLK_PERIOD_NS    = 10;
   localparam int ADDR_W           = 22;
   localparam int DATA_W           = 16;
   localparam int PAGE_WORDS       = 8;
   localparam int PAGE_BITS        = 3;
   // pin timing minimums in ns, counts round up
   localparam int READ_CYCLE_NS    = 70;
   localparam int WRITE_CYCLE_NS   = 70;
   localparam int PAGE_CYCLE_NS    = 30;
   localparam int WRITE_PULSE_NS   = 50;
   localparam int DATA_SETUP_NS    = 30;
   localparam int SELECT_HIGH_NS   = 10;
   localparam int OUT_HIZ_NS       = 20;
   localparam int READ_CYCLES      = (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WRITE_CYCLES     = (WRITE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PAGE_CYCLES      = (PAGE_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RECOVER_CYCLES   = (OUT_HIZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // long intervals in us / ms
   localparam int POWER_ON_HOLD_US = 30;
   localparam int REFRESH_SPAN_US  = 10;
   localparam int DEEP_PULSE_MS    = 10;
   localparam int DEEP_EXIT_US     = 300;
   localparam int POWER_ON_CYCLES  = POWER_ON_HOLD_US * 1000 / CLK_PERIOD_NS;
   localparam int REFRESH_CYCLES   = REFRESH_SPAN_US * 1000 / CLK_PERIOD_NS;
   localparam int DEEP_PULSE_CYCLES = DEEP_PULSE_MS * 1000000 / CLK_PERIOD_NS;
   localparam int DEEP_EXIT_CYCLES = DEEP_EXIT_US * 1000 / CLK_PERIOD_NS;
   localparam int CNT_W            = 24;

   typedef enum logic [1:0] {
      PSCTL_OP_READ,
      PSCTL_OP_WRITE,
      PSCTL_OP_PAGE,
      PSCTL_OP_SLEEP
   } psctl_op_e;
endpackage

// *** psctl_timer.sv ***
// down counter used for every pin interval except the power-on wait
// assumes load and count come from the same clock domain
`timescale 1ns/1ps
module psctl_timer
   import psctl_pkg::*;
#(
   parameter int W = CNT_W
) (
   input  wire logic         ref_clk,
   input  wire logic         reset_n,
   input  wire logic         load,
   input  wire logic [W-1:0] value,
   output logic              done
);
   logic [W-1:0] count;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         count <= '0;
      end else if (load) begin
         count <= value;
      end else if (count != '0) begin
         count <= count - 1'b1;
      end
   end

   // done depends on the count only; the caller's load may follow done without a loop
   assign done = (count == '0);
endmodule

// *** testbench.sv ***
// self-checking bench for the host controller with a ram model
// assumes shortened power-on, sleep and refresh counts
`timescale 1ns/1ps
module testbench
   import psctl_pkg::*;
;
   logic                 ref_clk, reset_n, req_valid, req_end_by_select, req_ready;
   logic                 rsp_valid, data_lost, select_n, power_select, output_en_n;
   logic                 write_n, low_lane_n, high_lane_n, mem_dq_oe;
   psctl_op_e            req_op;
   logic [ADDR_W-1:0]    req_addr, mem_addr;
   logic [DATA_W-1:0]    req_wdata, rsp_rdata, mem_dq_out, mem_dq_in;
   logic [1:0]           req_lanes;
   logic [PAGE_BITS-1:0] req_count;
   logic [DATA_W-1:0]    got [0:7];
   int                   fails = 0, comparisons = 0, cycles = 0;
   psctl_host #(.POWER_ON_WAIT(5), .DEEP_PULSE(10), .DEEP_EXIT(5), .REFRESH_SPAN(50)) DUT (
      .ref_clk, .reset_n, .req_valid, .req_op, .req_addr, .req_wdata, .req_lanes,
      .req_count, .req_end_by_select, .req_ready, .rsp_valid, .rsp_rdata, .data_lost,
      .mem_addr, .select_n, .power_select, .output_en_n, .write_n, .low_lane_n,
      .high_lane_n, .mem_dq_out, .mem_dq_oe, .mem_dq_in);
   psctl_mem_model u_mem (.mem_addr, .select_n, .power_select, .output_en_n, .write_n,
      .low_lane_n, .high_lane_n, .mem_dq_out, .mem_dq_oe, .mem_dq_in);
   task automatic final_report;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic check(input string nm, input logic [15:0] s, input logic [15:0] e);
      comparisons++;
      if (s !== e) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic step;
      @(posedge ref_clk);
      #1;
   endtask
   task automatic wait_idle;
      while (req_ready !== 1'b1) step;
   endtask
   task automatic access(input psctl_op_e op, input int a, input logic [15:0] d,
                         input logic [1:0] ln, input int c, input logic es, input int n);
      int k;
      k = 0;
      req_op = op;
      req_addr = a[ADDR_W-1:0];
      req_wdata = d;
      req_lanes = ln;
      req_count = c[PAGE_BITS-1:0];
      req_end_by_select = es;
      req_valid = 1'b1;
      wait_idle;
      step;
      req_valid = 1'b0;
      // let an edge pass so a following call never re-raises valid in this step
      step;
      while (k < n) begin
         step;
         if (rsp_valid === 1'b1) begin
            got[k] = rsp_rdata;
            k++;
         end
      end
   endtask
   task automatic t_word;
      access(PSCTL_OP_WRITE, 5, 16'h1234, 2'b11, 0, 1'b0, 0);
      access(PSCTL_OP_READ, 5, 16'h0, 2'b11, 0, 1'b0, 1);
      check("word", got[0], 16'h1234);
   endtask
   task automatic t_lanes;
      access(PSCTL_OP_WRITE, 5, 16'hffab, 2'b01, 0, 1'b1, 0);
      access(PSCTL_OP_WRITE, 5, 16'hcdff, 2'b10, 0, 1'b0, 0);
      access(PSCTL_OP_READ, 5, 16'h0, 2'b11, 0, 1'b0, 1);
      check("lanes", got[0], 16'hcdab);
   endtask
   task automatic t_page;
      for (int i = 0; i < 8; i++) access(PSCTL_OP_WRITE, 8 + i, 16'(256 + i), 2'b11, 0, i[0], 0);
      access(PSCTL_OP_PAGE, 13, 16'h0, 2'b11, 7, 1'b0, 8);
      for (int i = 0; i < 8; i++) check("page", got[i], 16'(256 + (i + 5) % 8));
   endtask
   task automatic t_sleep;
      access(PSCTL_OP_SLEEP, 0, 16'h0, 2'b11, 0, 1'b0, 0);
      wait_idle;
      check("lost", 16'(data_lost), 16'h1);
      access(PSCTL_OP_WRITE, 3, 16'h0f0f, 2'b11, 0, 1'b0, 0);
      wait_idle;
      check("kept", 16'(data_lost), 16'h0);
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         final_report;
      end
   end
   initial begin
      reset_n = 1'b0;
      req_valid = 1'b0;
      req_op = PSCTL_OP_READ;
      req_addr = '0;
      req_wdata = '0;
      req_lanes = '0;
      req_count = '0;
      req_end_by_select = 1'b0;
      repeat (10) @(posedge ref_clk);
      #1 reset_n = 1'b1;
      t_word;
      t_lanes;
      t_page;
      t_sleep;
      final_report;
   end
endmodule
